// file: design/rxsw_writeback.sv
// Receive descriptor status writeback: classify, write word 3, teardown
//
// Function
// - Teardown marks first free descriptor done
// - Torn-down queue is halted, untouched until software restarts it
// - Flag FCS included when CRC kept
// - Jabber: too long plus CRC/code/alignment error
// - Jabber flag when error frames copied
// - Oversize flag when error frames copied
// - Fragment flag when error frames copied
// - Undersized flag when short frames copied
// - Control flag when control frames copied
// - Overrun flag on overrun-aborted reception
// - Symbol error flag when error frames copied
// - Misalignment flag when error frames copied
// - FCS bad flag when error frames copied
// - Filter miss flag under copy-all or on overrun frames
// - Start-of-packet descriptor carries all flags
// - Flags high half-word, length low half-word
`timescale 1ns/1ps
`default_nettype none
`include "rxsw_params.svh"
module rxsw_writeback (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_frame_valid,
    input  wire rxsw_pkg::rxsw_frame_t  i_frame,
    output logic                        o_frame_ready,
    output logic                        o_frame_drop,
    input  wire logic                   i_tdown_valid,
    input  wire logic [`RXSW_CH_W-1:0]  i_tdown_chan,
    input  wire logic [31:0]            i_tdown_addr,
    output logic                        o_tdown_ready,
    output logic                        o_mem_valid,
    output logic [31:0]                 o_mem_addr,
    output logic [31:0]                 o_mem_wdata,
    input  wire logic                   i_mem_ready,
    input  wire logic [`RXSW_AW-1:0]    i_reg_addr,
    input  wire logic [31:0]            i_reg_wdata,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    output logic [31:0]                 o_reg_rdata,
    output logic                        o_irq
);
    import rxsw_pkg::*;

    localparam int NCH = `RXSW_NUM_CH;
    localparam int NEV = `RXSW_NUM_EV;

    function automatic logic hit(input logic [`RXSW_AW-1:0] a,
                                 input logic [`RXSW_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Register state
    rxsw_policy_t      rx_filter_policy_reg;
    logic [15:0]       rx_length_limit;
    logic [NCH-1:0]    halted;
    logic [NEV-1:0]    int_mask;
    logic [NEV-1:0]    int_status;

    // Engine state
    rxsw_state_t       state;
    rxsw_state_t       next_state;
    logic [`RXSW_CH_W-1:0] cur_chan;
    logic              cur_overrun;
    rxsw_class_t       cls;

    // Register decode
    wire wr_policy = i_reg_wr & hit(i_reg_addr, `RXSW_OFF_POLICY);
    wire wr_limit  = i_reg_wr & hit(i_reg_addr, `RXSW_OFF_LEN_LIMIT);
    wire wr_halt   = i_reg_wr & hit(i_reg_addr, `RXSW_OFF_HALT);
    wire wr_mask   = i_reg_wr & hit(i_reg_addr, `RXSW_OFF_INT_MASK);
    wire rd_status = i_reg_rd & hit(i_reg_addr, `RXSW_OFF_INT_STATUS);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            hit(i_reg_addr, `RXSW_OFF_POLICY):
                rd_mux[3:0] = rx_filter_policy_reg;
            hit(i_reg_addr, `RXSW_OFF_LEN_LIMIT):
                rd_mux[15:0] = rx_length_limit;
            hit(i_reg_addr, `RXSW_OFF_HALT):
                rd_mux[NCH-1:0] = halted;
            hit(i_reg_addr, `RXSW_OFF_INT_STATUS):
                rd_mux[NEV-1:0] = int_status;
            hit(i_reg_addr, `RXSW_OFF_INT_MASK):
                rd_mux[NEV-1:0] = int_mask;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // Classification of the offered frame
    rxsw_classify u_classify (
        .i_frame     (i_frame),
        .i_policy    (rx_filter_policy_reg),
        .i_len_limit (rx_length_limit),
        .o_class     (cls)
    );

    // Handshakes
    wire tdown_take = i_tdown_valid & o_tdown_ready;
    wire frame_take = i_frame_valid & o_frame_ready & ~tdown_take;
    wire chan_halt  = halted[i_frame.chan];
    // A halted queue gets no descriptor at all, whatever the frame
    wire frame_wb   = frame_take & ~chan_halt & cls.keep;
    wire frame_drop = frame_take & ~frame_wb;
    wire mem_done   = o_mem_valid & i_mem_ready;

    // Status word: flags over length, owner bit left clear to release
    wire [31:0] frame_word = {cls.flags, i_frame.len};
    logic [15:0] td_flags;
    always_comb begin
        td_flags = 16'h0000;
        td_flags[`RXSW_F_TDOWN] = 1'b1;
    end
    wire [31:0] tdown_word = {td_flags, 16'h0000};

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            RXSW_IDLE: begin
                if (tdown_take) begin
                    next_state = RXSW_TDOWN;
                end else if (frame_wb) begin
                    next_state = RXSW_WRITE;
                end
            end
            RXSW_WRITE: begin
                if (mem_done) begin
                    next_state = RXSW_IDLE;
                end
            end
            RXSW_TDOWN: begin
                if (mem_done) begin
                    next_state = RXSW_IDLE;
                end
            end
            default: next_state = RXSW_IDLE;
        endcase
    end

    // Ready only while the engine will be idle and starts no memory write now
    wire next_ready = (next_state == RXSW_IDLE) & ~tdown_take & ~frame_wb;

    // Events
    logic [NEV-1:0] events;
    always_comb begin
        events = '0;
        events[`RXSW_EV_WRITTEN] = mem_done & (state == RXSW_WRITE);
        events[`RXSW_EV_DROPPED] = frame_drop;
        events[`RXSW_EV_TDOWN]   = mem_done & (state == RXSW_TDOWN);
        events[`RXSW_EV_OVERRUN] = mem_done & (state == RXSW_WRITE)
                                   & cur_overrun;
    end

    // Halt set on teardown completion wins over a restart write
    logic [NCH-1:0] halt_set;
    always_comb begin
        halt_set = '0;
        if (events[`RXSW_EV_TDOWN]) begin
            halt_set[cur_chan] = 1'b1;
        end
    end
    wire [NCH-1:0] halt_clr  = wr_halt ? i_reg_wdata[NCH-1:0] : '0;
    wire [NCH-1:0] next_halt = (halted & ~halt_clr) | halt_set;

    // Registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            rx_filter_policy_reg <= `RXSW_RST_POLICY;
            rx_length_limit      <= `RXSW_RST_LEN_LIMIT;
            int_mask             <= `RXSW_RST_MASK;
            halted               <= '0;
            o_reg_rdata          <= 32'h0000_0000;
        end else begin
            if (wr_policy) begin
                rx_filter_policy_reg <= i_reg_wdata[3:0];
            end
            if (wr_limit) begin
                rx_length_limit <= i_reg_wdata[15:0];
            end
            if (wr_mask) begin
                int_mask <= i_reg_wdata[NEV-1:0];
            end
            halted      <= next_halt;
            o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Engine
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state         <= RXSW_IDLE;
            o_frame_ready <= 1'b0;
            o_tdown_ready <= 1'b0;
            o_frame_drop  <= 1'b0;
            cur_chan      <= '0;
            cur_overrun   <= 1'b0;
        end else begin
            state         <= next_state;
            o_frame_ready <= next_ready;
            o_tdown_ready <= next_ready;
            o_frame_drop  <= frame_drop;
            if (tdown_take) begin
                cur_chan <= i_tdown_chan;
            end else if (frame_wb) begin
                cur_chan    <= i_frame.chan;
                cur_overrun <= i_frame.overrun;
            end
        end
    end

    // Memory write port: held until the memory takes it
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_mem_valid <= 1'b0;
            o_mem_addr  <= 32'h0000_0000;
            o_mem_wdata <= 32'h0000_0000;
        end else if (tdown_take) begin
            o_mem_valid <= 1'b1;
            o_mem_addr  <= i_tdown_addr + `RXSW_WORD3_OFS;
            o_mem_wdata <= tdown_word;
        end else if (frame_wb) begin
            o_mem_valid <= 1'b1;
            o_mem_addr  <= i_frame.first_addr + `RXSW_WORD3_OFS;
            o_mem_wdata <= frame_word;
        end else if (mem_done) begin
            o_mem_valid <= 1'b0;
        end
    end

    // Interrupts
    rxsw_irq #(
        .N (NEV)
    ) u_irq (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_event   (events),
        .i_clear   (rd_status),
        .i_mask    (int_mask),
        .o_status  (int_status),
        .o_irq     (o_irq)
    );
endmodule
`default_nettype wire

// file: design/rxsw_params.svh
// Offsets, field positions, reset values and limits of the rx status writeback
`ifndef RXSW_PARAMS_SVH
`define RXSW_PARAMS_SVH
`define RXSW_AW              8
`define RXSW_CH_W            3
`define RXSW_NUM_CH          8
`define RXSW_OFF_POLICY      8'h00
`define RXSW_OFF_LEN_LIMIT   8'h04
`define RXSW_OFF_HALT        8'h08
`define RXSW_OFF_INT_STATUS  8'h0C
`define RXSW_OFF_INT_MASK    8'h10
`define RXSW_RST_POLICY      4'h0
`define RXSW_RST_LEN_LIMIT   16'h05EE
`define RXSW_RST_MASK        4'h0
`define RXSW_MIN_LEN         16'h0040
`define RXSW_WORD3_OFS       32'h0000_000C
`define RXSW_F_FIRST         15
`define RXSW_F_EOP           14
`define RXSW_F_OWNER         13
`define RXSW_F_EOQ           12
`define RXSW_F_TDOWN         11
`define RXSW_F_FCS_INC       10
`define RXSW_F_JABBER        9
`define RXSW_F_OVERSIZE      8
`define RXSW_F_FRAGMENT      7
`define RXSW_F_UNDERSIZED    6
`define RXSW_F_CONTROL       5
`define RXSW_F_OVERRUN       4
`define RXSW_F_SYMBOL        3
`define RXSW_F_MISALIGN      2
`define RXSW_F_FCS_BAD       1
`define RXSW_F_MISS          0
`define RXSW_EV_WRITTEN      0
`define RXSW_EV_DROPPED      1
`define RXSW_EV_TDOWN        2
`define RXSW_EV_OVERRUN      3
`define RXSW_NUM_EV          4
`endif

// file: design/rxsw_pkg.sv
// Types shared by the rx status writeback modules
`include "rxsw_params.svh"
package rxsw_pkg;
    typedef struct packed {
        logic [31:0]            first_addr;
        logic [`RXSW_CH_W-1:0]  chan;
        logic [15:0]            len;
        logic                   fcs_kept;
        logic                   crc_err;
        logic                   code_err;
        logic                   align_err;
        logic                   overrun;
        logic                   ctrl;
        logic                   addr_match;
        logic                   single_buf;
        logic                   last_in_queue;
    } rxsw_frame_t;

    typedef struct packed {
        logic copy_all_frames_enable;
        logic copy_control_frames_enable;
        logic copy_short_frames_enable;
        logic copy_error_frames_enable;
    } rxsw_policy_t;

    typedef struct packed {
        logic        keep;
        logic [15:0] flags;
    } rxsw_class_t;

    typedef enum logic [2:0] {
        RXSW_IDLE  = 3'b001,
        RXSW_WRITE = 3'b010,
        RXSW_TDOWN = 3'b100
    } rxsw_state_t;
endpackage

// file: design/rxsw_classify.sv
// Frame classification into descriptor status flags and keep decision
`timescale 1ns/1ps
`default_nettype none
`include "rxsw_params.svh"
module rxsw_classify (
    input  wire rxsw_pkg::rxsw_frame_t  i_frame,
    input  wire rxsw_pkg::rxsw_policy_t i_policy,
    input  wire logic [15:0]            i_len_limit,
    output rxsw_pkg::rxsw_class_t       o_class
);
    import rxsw_pkg::*;
    wire any_err  = i_frame.crc_err | i_frame.code_err | i_frame.align_err;
    wire too_long = i_frame.len > i_len_limit;
    wire too_short = i_frame.len < `RXSW_MIN_LEN;
    wire jabber   = too_long & any_err;
    wire oversize = too_long & ~any_err;
    wire fragment = too_short & any_err;
    wire undersz  = too_short & ~any_err;
    wire err_cls  = any_err | too_long | fragment;
    wire miss     = ~i_frame.addr_match;
    // Overrun frames are always kept, so software sees the abort unless their queue is halted
    wire keep_err = ~err_cls | i_policy.copy_error_frames_enable;
    wire keep_sht = ~undersz | i_policy.copy_short_frames_enable;
    wire keep_ctl = ~i_frame.ctrl | i_policy.copy_control_frames_enable;
    wire keep_all = ~miss | i_policy.copy_all_frames_enable;
    wire keep     = i_frame.overrun | (keep_err & keep_sht & keep_ctl & keep_all);
    logic [15:0] f;
    always_comb begin
        f                       = 16'h0000;
        f[`RXSW_F_FIRST]        = 1'b1;
        f[`RXSW_F_EOP]          = i_frame.single_buf;
        f[`RXSW_F_EOQ]          = i_frame.single_buf & i_frame.last_in_queue;
        f[`RXSW_F_FCS_INC]      = i_frame.fcs_kept;
        f[`RXSW_F_JABBER]       = jabber;
        f[`RXSW_F_OVERSIZE]     = oversize;
        f[`RXSW_F_FRAGMENT]     = fragment;
        f[`RXSW_F_UNDERSIZED]   = undersz;
        f[`RXSW_F_CONTROL]      = i_frame.ctrl;
        f[`RXSW_F_OVERRUN]      = i_frame.overrun;
        f[`RXSW_F_SYMBOL]       = i_frame.code_err;
        f[`RXSW_F_MISALIGN]     = i_frame.align_err;
        f[`RXSW_F_FCS_BAD]      = i_frame.crc_err;
        f[`RXSW_F_MISS]         = miss & ~err_cls & ~undersz;
    end
    assign o_class = '{keep: keep, flags: f};
endmodule
`default_nettype wire

// file: design/rxsw_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rxsw_params.svh"
module rxsw_irq #(
    parameter int N = `RXSW_NUM_EV
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rstn,
    input  wire logic [N-1:0] i_event,
    input  wire logic         i_clear,
    input  wire logic [N-1:0] i_mask,
    output logic [N-1:0]      o_status,
    output logic              o_irq
);
    // A new event in the clearing cycle survives the clear
    wire [N-1:0] next_status = (i_clear ? {N{1'b0}} : o_status) | i_event;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_status <= {N{1'b0}};
            o_irq    <= 1'b0;
        end else begin
            o_status <= next_status;
            o_irq    <= |(next_status & i_mask);
        end
    end
endmodule
`default_nettype wire

// file: dv/rxsw_writeback_props.sv
// Port-level checks of the rx status writeback
`timescale 1ns/1ps
`default_nettype none
module rxsw_writeback_props (
    input wire logic                  i_sys_clk,
    input wire logic                  i_rstn,
    input wire logic                  i_frame_valid,
    input wire rxsw_pkg::rxsw_frame_t i_frame,
    input wire logic                  o_frame_ready,
    input wire logic                  o_frame_drop,
    input wire logic                  i_tdown_valid,
    input wire logic [31:0]           i_tdown_addr,
    input wire logic                  o_tdown_ready,
    input wire logic                  o_mem_valid,
    input wire logic [31:0]           o_mem_addr,
    input wire logic [31:0]           o_mem_wdata,
    input wire logic                  i_mem_ready
);
    import rxsw_pkg::*;
    // Teardown wins the edge, so a frame is only taken without one
    wire logic take = i_frame_valid && o_frame_ready && !i_tdown_valid;
    wire logic tdn  = i_tdown_valid && o_tdown_ready;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    a_mem_hold: assert property (o_mem_valid && !i_mem_ready |=>
        o_mem_valid && $stable(o_mem_addr) && $stable(o_mem_wdata)) else $error("write changed before accept");
    a_word_addr: assert property (take |=> o_frame_drop ||
        (o_mem_valid && o_mem_addr == $past(i_frame.first_addr) + 32'h0000_000C)) else $error("bad word address");
    a_len_low: assert property (take |=> !o_mem_valid ||
        o_mem_wdata[15:0] == $past(i_frame.len)) else $error("bad packet length");
    a_sop_owner: assert property (take |=> !o_mem_valid ||
        (o_mem_wdata[31] && !o_mem_wdata[29])) else $error("bad start or owner flag");
    a_fcs_flag: assert property (take |=> !o_mem_valid ||
        o_mem_wdata[26] == $past(i_frame.fcs_kept)) else $error("bad fcs flag");
    a_overrun_flag: assert property (take && i_frame.overrun |=> o_frame_drop ||
        (o_mem_valid && o_mem_wdata[20])) else $error("overrun flag missing");
    a_tdown_word: assert property (tdn |=> o_mem_valid && o_mem_wdata == 32'h0800_0000 &&
        o_mem_addr == $past(i_tdown_addr) + 32'h0000_000C) else $error("bad teardown write");
    // Back-to-back drops are legal, so each drop must follow its own take
    a_drop_clean: assert property (o_frame_drop |-> !o_mem_valid && $past(take))
        else $error("dropped frame wrote memory");
endmodule
`default_nettype wire

// file: dv/rxsw_mem_model.sv
// Descriptor memory seen by the writeback, prompt or stalling
`timescale 1ns/1ps
`default_nettype none
module rxsw_mem_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_slow,
    input  wire logic        i_mem_valid,
    input  wire logic [31:0] i_mem_addr,
    input  wire logic [31:0] i_mem_wdata,
    output logic             o_mem_ready,
    output logic [31:0]      o_addr,
    output logic [31:0]      o_word,
    output logic [7:0]       o_count
);
    logic [1:0] wait_cnt;
    // Slow mode stalls each write two cycles
    assign o_mem_ready = i_mem_valid && (!i_slow || wait_cnt == 2'h2);
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            wait_cnt <= 2'h0;
            o_addr   <= 32'h0000_0000;
            o_word   <= 32'h0000_0000;
            o_count  <= 8'h00;
        end else if (o_mem_ready) begin
            wait_cnt <= 2'h0;
            o_addr   <= i_mem_addr;
            o_word   <= i_mem_wdata;
            o_count  <= o_count + 8'h01;
        end else if (i_mem_valid) begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: dv/tb_rxsw_writeback.sv
// Self-checking bench of the rx status writeback
`timescale 1ns/1ps
`default_nettype none
`include "rxsw_params.svh"
module tb_rxsw_writeback;
    import rxsw_pkg::*;
    localparam logic [15:0] DROP = 16'hFFFF;
    logic                i_sys_clk, i_rstn, i_frame_valid, i_tdown_valid, i_reg_wr, i_reg_rd, slow;
    logic                o_frame_ready, o_frame_drop, o_tdown_ready, o_mem_valid, i_mem_ready, o_irq;
    rxsw_frame_t         i_frame;
    logic [2:0]          i_tdown_chan;
    logic [`RXSW_AW-1:0] i_reg_addr;
    logic [31:0]         i_tdown_addr, i_reg_wdata, o_mem_addr, o_mem_wdata, o_reg_rdata, w_addr, w_word, rd;
    logic [7:0]          w_count;
    int                  num_errors = 0, n_tests = 0, cycles = 0;

    rxsw_writeback dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_frame_valid(i_frame_valid),
        .i_frame(i_frame), .o_frame_ready(o_frame_ready), .o_frame_drop(o_frame_drop),
        .i_tdown_valid(i_tdown_valid), .i_tdown_chan(i_tdown_chan), .i_tdown_addr(i_tdown_addr),
        .o_tdown_ready(o_tdown_ready), .o_mem_valid(o_mem_valid), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .i_mem_ready(i_mem_ready), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .o_irq(o_irq));
    rxsw_mem_model mem (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_slow(slow), .i_mem_valid(o_mem_valid),
        .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_ready(i_mem_ready), .o_addr(w_addr),
        .o_word(w_word), .o_count(w_count));

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Extra edge after the strobe keeps a following task off the same step
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr    <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic reg_rd(input logic [7:0] a);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd   <= 1'b0;
        @(posedge i_sys_clk);
        rd = o_reg_rdata;
    endtask

    // b: chan[11:9] last_q multi_buf no_match fcs crc code align overrun ctrl
    task automatic send(input logic [3:0] pol, input logic [15:0] len, input logic [11:0] b,
                        input logic [15:0] ef);
        rxsw_frame_t f;
        logic [7:0]  c0;
        int          k;
        reg_wr(`RXSW_OFF_POLICY, {28'h0, pol});
        f = '0;
        f.first_addr = {12'h0, len, 4'h0};
        f.len = len;
        {f.chan, f.last_in_queue, f.single_buf, f.addr_match, f.fcs_kept, f.crc_err, f.code_err,
            f.align_err, f.overrun, f.ctrl} = b ^ 12'h0C0;
        c0 = w_count;
        i_frame       <= f;
        i_frame_valid <= 1'b1;
        k = 0;
        do begin @(posedge i_sys_clk); k++; end while (!o_frame_ready && k < 50);
        i_frame_valid <= 1'b0;
        k = 0;
        do begin @(posedge i_sys_clk); k++; end while (!o_frame_drop && w_count == c0 && k < 50);
        chk({30'h0, o_frame_drop, w_count == c0}, (ef == DROP) ? 32'h3 : 32'h0);
        if (ef != DROP) begin
            chk(w_word, {ef, len});
            chk(w_addr, f.first_addr + 32'h0000_000C);
        end
    endtask

    // A competing frame is offered too; the teardown must win the edge
    task automatic tdown(input logic [2:0] ch);
        logic [7:0] c0;
        int         k;
        c0 = w_count;
        i_tdown_chan  <= ch;
        i_tdown_addr  <= 32'h0000_2000;
        i_tdown_valid <= 1'b1;
        i_frame_valid <= 1'b1;
        k = 0;
        do begin @(posedge i_sys_clk); k++; end while (!o_tdown_ready && k < 50);
        i_tdown_valid <= 1'b0;
        i_frame_valid <= 1'b0;
        k = 0;
        do begin @(posedge i_sys_clk); k++; end while (w_count == c0 && k < 50);
        repeat (3) @(posedge i_sys_clk);
        chk(w_word, 32'h0800_0000);
        chk(w_addr, 32'h0000_200C);
        chk({24'h0, w_count}, {24'h0, c0 + 8'h01});
    endtask

    // Overrun write raises its status bits; the interrupt follows the mask
    task automatic irq_scenario();
        reg_rd(`RXSW_OFF_INT_STATUS);
        send(4'h0, 16'd100, 12'h002, 16'hC010);
        repeat (2) @(posedge i_sys_clk);
        chk({31'h0, o_irq}, 32'h0);
        reg_wr(`RXSW_OFF_INT_MASK, 32'h0000_0008);
        @(posedge i_sys_clk);
        chk({31'h0, o_irq}, 32'h1);
        reg_rd(`RXSW_OFF_INT_STATUS);
        chk(rd, 32'h0000_0009);
        @(posedge i_sys_clk);
        chk({31'h0, o_irq}, 32'h0);
        reg_rd(`RXSW_OFF_INT_MASK);
        chk(rd, 32'h0000_0008);
    endtask

    // A torn-down queue drops its frames until software restarts it
    task automatic halt_scenario();
        tdown(3'h2);
        reg_rd(`RXSW_OFF_HALT);
        chk(rd, 32'h0000_0004);
        send(4'h0, 16'd100, 12'h400, DROP);
        reg_wr(`RXSW_OFF_HALT, 32'h0000_0004);
        send(4'h0, 16'd100, 12'h400, 16'hC000);
    endtask

    // A lowered limit must act on classification; reset brings it back
    task automatic reset_scenario();
        reg_wr(`RXSW_OFF_LEN_LIMIT, 32'h0000_0100);
        reg_rd(`RXSW_OFF_LEN_LIMIT);
        chk(rd, 32'h0000_0100);
        send(4'h0, 16'd300, 12'h000, DROP);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        chk({31'h0, o_frame_ready}, 32'h1);
        reg_rd(`RXSW_OFF_LEN_LIMIT);
        chk(rd, 32'h0000_05EE);
        reg_rd(`RXSW_OFF_INT_MASK);
        chk(rd, 32'h0000_0000);
        send(4'h0, 16'd300, 12'h020, 16'hC400);
    endtask

    initial begin
        i_rstn = 1'b0;
        i_frame_valid = 1'b0;
        i_frame = '0;
        i_tdown_valid = 1'b0;
        i_tdown_chan = 3'h0;
        i_tdown_addr = 32'h0000_0000;
        i_reg_addr = '0;
        i_reg_wdata = 32'h0000_0000;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        slow = 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(posedge i_sys_clk);
        reg_rd(`RXSW_OFF_LEN_LIMIT);
        chk(rd, 32'h0000_05EE);
        reg_rd(8'h14);
        chk(rd, 32'h0000_0000);
        send(4'h0, 16'd100, 12'h020, 16'hC400);
        send(4'h0, 16'd100, 12'h010, DROP);
        send(4'h1, 16'd100, 12'h010, 16'hC002);
        send(4'h1, 16'd100, 12'h008, 16'hC008);
        send(4'h1, 16'd100, 12'h004, 16'hC004);
        send(4'h1, 16'd1600, 12'h010, 16'hC202);
        slow <= 1'b1;
        send(4'h1, 16'd1519, 12'h000, 16'hC100);
        send(4'h0, 16'd1518, 12'h000, 16'hC000);
        send(4'h1, 16'd40, 12'h010, 16'hC082);
        send(4'h2, 16'd63, 12'h000, 16'hC040);
        send(4'h1, 16'd63, 12'h000, DROP);
        send(4'h0, 16'd64, 12'h000, 16'hC000);
        send(4'h4, 16'd100, 12'h001, 16'hC020);
        send(4'h0, 16'd100, 12'h001, DROP);
        send(4'h8, 16'd100, 12'h040, 16'hC001);
        send(4'h0, 16'd100, 12'h040, DROP);
        send(4'h0, 16'd100, 12'h080, 16'h8000);
        send(4'h0, 16'd100, 12'h100, 16'hD000);
        irq_scenario();
        halt_scenario();
        reset_scenario();
        summarize();
    end
endmodule
bind rxsw_writeback rxsw_writeback_props u_props (.*);
`default_nettype wire
